// File: include/ovd_pkg.sv
// Shared constants and types for the overcurrent response and diag switch block
package ovd_pkg;

  // Register offsets
  localparam logic [7:0] REG_AO_CFG = 8'h02;
  localparam logic [7:0] REG_CHNL   = 8'h03;
  localparam logic [7:0] REG_STAT   = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h11;
  localparam logic [7:0] REG_STATE  = 8'h12;

  // Field positions
  localparam int AO_CFG_LSB  = 16;
  localparam int OVC_SEL_BIT = 3;
  localparam int DIAG_MSB    = 23;
  localparam int CHSEL_LSB   = 8;
  localparam int RSVD_W      = 8;

  // Output configuration codes
  localparam logic [3:0] CFG_HIZ   = 4'h0;
  localparam logic [3:0] CFG_V25   = 4'h1;
  localparam logic [3:0] CFG_V12P5 = 4'h2;
  localparam logic [3:0] CFG_I25   = 4'h6;
  localparam logic [3:0] CFG_I2P5  = 4'h8;

  // Reset values
  localparam logic [23:0] CHNL_RST  = 24'h000000;
  localparam logic [3:0]  CFG_RST   = 4'h0;
  localparam logic        OVC_SEL_RST = 1'b0;

  // Retry interval
  localparam int RETRY_MS          = 6;
  localparam int CLK_KHZ           = 100000;
  localparam int RETRY_CYCLES_DFLT = RETRY_MS * CLK_KHZ;

  typedef enum logic [0:0] {ST_RUN, ST_RETRY} ovd_state_t;

  // Sticky events
  typedef struct packed {
    logic inv_cfg;
    logic ovc_gone;
    logic ovc_hit;
  } ovd_evt_t;

  function automatic logic cfg_valid(input logic [3:0] c);
    return (c == CFG_HIZ) || (c == CFG_V25) || (c == CFG_V12P5) ||
           (c == CFG_I25) || (c == CFG_I2P5);
  endfunction

  function automatic logic cfg_vmode(input logic [3:0] c);
    return (c == CFG_V25) || (c == CFG_V12P5);
  endfunction

endpackage

// File: rtl/ovd_ctrl.sv
// Overcurrent response control and channel diag/select register bank
//
// Operation
// (RQ1) Select 0: overcurrent in voltage mode goes high impedance, retries every 6ms.
// (RQ2) Automatic mode: retry finding overcurrent gone restores previous output config.
// (RQ3) Select 1: overcurrent goes high impedance and clears output config to 0000.
// (RQ4) After host shutdown output stays high impedance until software writes config.
// (RQ5) Diag field: 00 open, 01 ground, 10 high supply, 11 both.
// (RQ6) Response select acts only in voltage output mode.
// (RQ7) Voltage modes are 0001 and 0010; high impedance is 0000.
// (RQ8) Channel register bits 7..0 read zero and ignore writes.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module ovd_ctrl #(
  parameter int RETRY_CYCLES = ovd_pkg::RETRY_CYCLES_DFLT  // Retry interval in clocks
) (
  input  wire logic        clk,       // Device clock, 100 MHz
  input  wire logic        rst,       // Async reset, active high
  input  wire logic [7:0]  addr,      // Register address
  input  wire logic [23:0] wdata,     // Write data
  input  wire logic        wr_en,     // Write strobe
  input  wire logic        rd_en,     // Read strobe
  output logic      [23:0] rdata,     // Read data, cycle after rd_en
  input  wire logic        ovc_pin,   // Overcurrent detect, asynchronous
  output logic      [3:0]  ao_cfg,    // Effective output configuration
  output logic             ao_hiz,    // Output held high impedance
  output logic      [3:0]  chan_sel,  // Conversion channel select
  output logic      [5:0]  diag_gnd,  // Diag path to ground, input 1 at bit 0
  output logic      [5:0]  diag_hi,   // Diag path to high supply
  output logic             irq        // Level interrupt
);

  // Parameter check
  generate
    if (RETRY_CYCLES < 2) begin : g_bad
      $error("RETRY_CYCLES must be at least 2");
    end
  endgenerate

  localparam logic [31:0] RETRY_LAST = 32'(RETRY_CYCLES - 1);

  logic ovc_s;

  // Overcurrent pin crosses in through two flops
  ovd_sync2 u_sync (
    .clk (clk),
    .rst (rst),
    .d   (ovc_pin),
    .q   (ovc_s)
  );

  ovd_pkg::ovd_state_t st_reg;
  ovd_pkg::ovd_state_t st_next;
  logic [31:0]         cnt_reg;
  logic [31:0]         cnt_next;
  logic [3:0]          cfg_reg;
  logic [3:0]          cfg_next;
  logic                sel_reg;
  logic                sel_next;
  logic [23:0]         chan_reg;
  logic [23:0]         chan_next;
  ovd_pkg::ovd_evt_t   stat_reg;
  ovd_pkg::ovd_evt_t   stat_next;
  ovd_pkg::ovd_evt_t   mask_reg;
  ovd_pkg::ovd_evt_t   mask_next;
  ovd_pkg::ovd_evt_t   evt;
  ovd_pkg::ovd_evt_t   w1c;
  logic [3:0]          aocfg_reg;
  logic [3:0]          aocfg_next;
  logic                hiz_reg;
  logic                hiz_next;
  logic                irq_reg;
  logic                irq_next;
  logic [23:0]         rdata_reg;
  logic [23:0]         rdata_next;
  logic [3:0]          wcfg;
  logic                wr_ao;

  assign wcfg  = wdata[ovd_pkg::AO_CFG_LSB +: 4];
  assign wr_ao = wr_en && (addr == ovd_pkg::REG_AO_CFG);

  // Register writes, response state machine and events
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    cfg_next  = cfg_reg;
    sel_next  = sel_reg;
    chan_next = chan_reg;
    mask_next = mask_reg;
    evt       = '0;
    w1c       = '0;
    if (wr_ao) begin
      sel_next = wdata[ovd_pkg::OVC_SEL_BIT];
      // Config is frozen during an automatic retry so the restore stays intact
      if (st_reg == ovd_pkg::ST_RUN) begin
        if (ovd_pkg::cfg_valid(wcfg)) begin
          cfg_next = wcfg;  // [RQ4]
        end else begin
          evt.inv_cfg = 1'b1;
        end
      end
    end
    if (wr_en && (addr == ovd_pkg::REG_CHNL)) begin
      chan_next = {wdata[23:ovd_pkg::RSVD_W], 8'h00};  // [RQ8]
    end
    if (wr_en && (addr == ovd_pkg::REG_MASK)) begin
      mask_next = wdata[2:0];
    end
    if (wr_en && (addr == ovd_pkg::REG_STAT)) begin
      w1c = wdata[2:0];
    end
    unique case (st_reg)
      ovd_pkg::ST_RUN: begin
        // Only voltage modes react to the select bit
        if (ovc_s && ovd_pkg::cfg_vmode(cfg_reg)) begin  // [RQ6] [RQ7]
          evt.ovc_hit = 1'b1;
          if (!sel_reg) begin
            st_next  = ovd_pkg::ST_RETRY;  // [RQ1]
            cnt_next = 32'h0;
          end else begin
            cfg_next = ovd_pkg::CFG_HIZ;  // [RQ3]
          end
        end
      end
      ovd_pkg::ST_RETRY: begin
        if (cnt_reg == RETRY_LAST) begin
          cnt_next = 32'h0;  // [RQ1]
          if (!ovc_s) begin
            st_next      = ovd_pkg::ST_RUN;  // [RQ2]
            evt.ovc_gone = 1'b1;
          end
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
    endcase
    // A new event beats a clear in the same cycle
    stat_next = (stat_reg & ~w1c) | evt;
  end

  // Output drive follows state: retry or code 0000 means high impedance
  always_comb begin
    aocfg_next = (st_next == ovd_pkg::ST_RETRY) ? ovd_pkg::CFG_HIZ : cfg_next;  // [RQ1]
    hiz_next   = (aocfg_next == ovd_pkg::CFG_HIZ);  // [RQ4] [RQ7]
    irq_next   = |(stat_next & mask_next);
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rdata_next = 24'h000000;
    if (rd_en) begin
      case (addr)
        ovd_pkg::REG_AO_CFG: begin
          rdata_next[ovd_pkg::AO_CFG_LSB +: 4] = cfg_reg;
          rdata_next[ovd_pkg::OVC_SEL_BIT]     = sel_reg;
        end
        ovd_pkg::REG_CHNL:  rdata_next = chan_reg;  // [RQ8]
        ovd_pkg::REG_STAT:  rdata_next[2:0] = stat_reg;
        ovd_pkg::REG_MASK:  rdata_next[2:0] = mask_reg;
        ovd_pkg::REG_STATE: rdata_next[1:0] = {ovc_s, st_reg == ovd_pkg::ST_RETRY};
        default:            rdata_next = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg    <= ovd_pkg::ST_RUN;
      cnt_reg   <= 32'h0;
      cfg_reg   <= ovd_pkg::CFG_RST;
      sel_reg   <= ovd_pkg::OVC_SEL_RST;
      chan_reg  <= ovd_pkg::CHNL_RST;
      stat_reg  <= '0;
      mask_reg  <= '0;
      aocfg_reg <= ovd_pkg::CFG_HIZ;
      hiz_reg   <= 1'b1;
      irq_reg   <= 1'b0;
      rdata_reg <= 24'h000000;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      cfg_reg   <= cfg_next;
      sel_reg   <= sel_next;
      chan_reg  <= chan_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      aocfg_reg <= aocfg_next;
      hiz_reg   <= hiz_next;
      irq_reg   <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  // Diag switch drivers, one per analog input
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_diag
      ovd_diag_sw u_sw (
        .clk    (clk),
        .rst    (rst),
        .code   (chan_reg[ovd_pkg::DIAG_MSB - 2*gi -: 2]),
        .to_gnd (diag_gnd[gi]),
        .to_hi  (diag_hi[gi])
      );
    end
  endgenerate

  // Channel select is a registered copy of the stored field; it lands one cycle after the channel register
  logic [3:0] chsel_reg;
  logic [3:0] chsel_next;

  always_comb begin
    chsel_next = chan_reg[ovd_pkg::CHSEL_LSB +: 4];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chsel_reg <= 4'h0;
    end else begin
      chsel_reg <= chsel_next;
    end
  end

  assign rdata    = rdata_reg;
  assign ao_cfg   = aocfg_reg;
  assign ao_hiz   = hiz_reg;
  assign chan_sel = chsel_reg;
  assign irq      = irq_reg;

  // Checks
  logic trip_auto;
  logic trip_host;
  logic retry_end;

  assign trip_auto = (st_reg == ovd_pkg::ST_RUN) && ovc_s &&
                     ovd_pkg::cfg_vmode(cfg_reg) && !sel_reg;
  assign trip_host = (st_reg == ovd_pkg::ST_RUN) && ovc_s &&
                     ovd_pkg::cfg_vmode(cfg_reg) && sel_reg;
  assign retry_end = (st_reg == ovd_pkg::ST_RETRY) && (cnt_reg == RETRY_LAST);

  property p_rq1_trip;
    @(posedge clk) disable iff (rst)
    trip_auto |=> ao_hiz && (st_reg == ovd_pkg::ST_RETRY) && (cnt_reg == 32'h0);
  endproperty
  a_rq1_trip: assert property (p_rq1_trip) else $error("auto trip not hiz"); // [RQ1]

  property p_rq1_retry;
    @(posedge clk) disable iff (rst)
    (retry_end && ovc_s) |=> (st_reg == ovd_pkg::ST_RETRY) && (cnt_reg == 32'h0) && ao_hiz;
  endproperty
  a_rq1_retry: assert property (p_rq1_retry) else $error("retry did not restart"); // [RQ1]

  property p_rq2_restore;
    @(posedge clk) disable iff (rst)
    (retry_end && !ovc_s) |=> !ao_hiz && (ao_cfg == $past(cfg_reg));
  endproperty
  a_rq2_restore: assert property (p_rq2_restore) else $error("config not restored"); // [RQ2]

  property p_rq3_host;
    @(posedge clk) disable iff (rst)
    trip_host |=> (cfg_reg == ovd_pkg::CFG_HIZ) && ao_hiz;
  endproperty
  a_rq3_host: assert property (p_rq3_host) else $error("host trip not cleared"); // [RQ3]

  property p_rq4_hold;
    @(posedge clk) disable iff (rst)
    (cfg_reg == ovd_pkg::CFG_HIZ) && (st_reg == ovd_pkg::ST_RUN) && !wr_ao
      |=> ao_hiz && (cfg_reg == ovd_pkg::CFG_HIZ);
  endproperty
  a_rq4_hold: assert property (p_rq4_hold) else $error("hiz left without write"); // [RQ4]

  property p_rq5_diag;
    @(posedge clk) disable iff (rst)
    1'b1 |=> (diag_gnd[0] == $past(chan_reg[22])) && (diag_hi[0] == $past(chan_reg[23]))
          && (diag_gnd[5] == $past(chan_reg[12])) && (diag_hi[5] == $past(chan_reg[13]));
  endproperty
  a_rq5_diag: assert property (p_rq5_diag) else $error("diag decode wrong"); // [RQ5]

  property p_rq6_other;
    @(posedge clk) disable iff (rst)
    (st_reg == ovd_pkg::ST_RUN) && !ovd_pkg::cfg_vmode(cfg_reg) |=> st_reg == ovd_pkg::ST_RUN;
  endproperty
  a_rq6_other: assert property (p_rq6_other) else $error("select acted outside vmode"); // [RQ6]

  property p_rq7_codes;
    @(posedge clk) disable iff (rst)
    (st_reg == ovd_pkg::ST_RETRY) |-> ovd_pkg::cfg_vmode(cfg_reg) && ao_hiz;
  endproperty
  a_rq7_codes: assert property (p_rq7_codes) else $error("retry outside vmode"); // [RQ7]

  property p_rq8_rsvd;
    @(posedge clk) disable iff (rst)
    (rd_en && (addr == ovd_pkg::REG_CHNL)) |=> (rdata[7:0] == 8'h00) && (chan_reg[7:0] == 8'h00);
  endproperty
  a_rq8_rsvd: assert property (p_rq8_rsvd) else $error("reserved bits not zero"); // [RQ8]

  c_auto: cover property (@(posedge clk) disable iff (rst) retry_end && !ovc_s);
  c_host: cover property (@(posedge clk) disable iff (rst) trip_host);
  c_irq:  cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_again: cover property (@(posedge clk) disable iff (rst) retry_end && ovc_s);

endmodule

// File: rtl/ovd_diag_sw.sv
// Registered decode of one 2-bit diagnostic switch field
`timescale 1ns/1ps
module ovd_diag_sw (
  input  wire logic       clk,     // Device clock
  input  wire logic       rst,     // Async reset
  input  wire logic [1:0] code,    // Switch field
  output logic            to_gnd,  // Path to analog ground closed
  output logic            to_hi    // Path to high supply closed
);
  logic gnd_reg;
  logic gnd_next;
  logic hi_reg;
  logic hi_next;

  // 00 open, 01 ground, 10 high supply, 11 both
  always_comb begin
    gnd_next = code[0];  // [RQ5]
    hi_next  = code[1];  // [RQ5]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gnd_reg <= 1'b0;
      hi_reg  <= 1'b0;
    end else begin
      gnd_reg <= gnd_next;
      hi_reg  <= hi_next;
    end
  end

  assign to_gnd = gnd_reg;
  assign to_hi  = hi_reg;
endmodule

// File: rtl/ovd_sync2.sv
// Two-flop synchroniser for the overcurrent detect pin
`timescale 1ns/1ps
module ovd_sync2 (
  input  wire logic clk,  // Device clock
  input  wire logic rst,  // Async reset
  input  wire logic d,    // Asynchronous level
  output logic      q     // Synchronised level
);
  logic meta_reg;
  logic q_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q_reg    <= 1'b0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// File: tb/ovd_tb.sv
// Self-checking testbench for the overcurrent response and diag switch block
`timescale 1ns/1ps
module tb;
  localparam int RETRY = 8;  // Short retry interval keeps the run brief

  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [23:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [23:0] rdata;
  logic        ovc_pin;
  logic [3:0]  ao_cfg;
  logic        ao_hiz;
  logic [3:0]  chan_sel;
  logic [5:0]  diag_gnd;
  logic [5:0]  diag_hi;
  logic        irq;
  int          errors;
  int          compares;

  ovd_ctrl #(.RETRY_CYCLES(RETRY)) uut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .ovc_pin(ovc_pin), .ao_cfg(ao_cfg), .ao_hiz(ao_hiz),
    .chan_sel(chan_sel), .diag_gnd(diag_gnd), .diag_hi(diag_hi), .irq(irq)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle write; the extra 1 ns lets the edge's updates land before checks
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic set_ovc(input logic v);
    @(posedge clk);
    ovc_pin <= v;
  endtask

  task automatic t_reset();
    logic [23:0] d;
    rd(ovd_pkg::REG_CHNL, d);
    chk("chnl reset", 24'h000000, d);
    chk("ao_hiz reset", 24'h000001, 24'(ao_hiz));
    chk("irq reset", 24'h000000, 24'(irq));
    rd(8'h7f, d);
    chk("unmapped read", 24'h000000, d);
    $display("test reset done");
  endtask

  // Every code in every field, adjacent fields holding different codes
  task automatic t_diag();
    logic [23:0] d;
    logic [23:0] p;
    logic [5:0]  g;
    logic [5:0]  h;
    logic [1:0]  c;
    for (int i = 0; i < 4; i++) begin
      p = 24'h000000;
      for (int k = 0; k < 6; k++) begin
        c = 2'(i + k);
        p[23 - 2 * k -: 2] = c;
        g[k] = c[0];
        h[k] = c[1];
      end
      p[11:8] = 4'(i + 5);
      wr(ovd_pkg::REG_CHNL, p | 24'h0000ff);
      rd(ovd_pkg::REG_CHNL, d);
      chk("chnl readback", p, d);
      chk("diag_gnd", 24'(g), 24'(diag_gnd));
      chk("diag_hi", 24'(h), 24'(diag_hi));
      chk("chan_sel", 24'(p[11:8]), 24'(chan_sel));
    end
    $display("test diag done");
  endtask

  task automatic t_auto();
    logic [23:0] d;
    int          n;
    wr(ovd_pkg::REG_MASK, 24'h000003);
    wr(ovd_pkg::REG_AO_CFG, 24'h010000);
    chk("ao_cfg v25", 24'h000001, 24'(ao_cfg));
    chk("ao_hiz v25", 24'h000000, 24'(ao_hiz));
    set_ovc(1'b1);
    cyc(5);
    chk("ao_hiz trip", 24'h000001, 24'(ao_hiz));
    chk("ao_cfg trip", 24'h000000, 24'(ao_cfg));
    chk("irq trip", 24'h000001, 24'(irq));
    cyc(3 * RETRY);
    chk("ao_hiz persist", 24'h000001, 24'(ao_hiz));
    rd(ovd_pkg::REG_STATE, d);
    chk("state retry", 24'h000003, d & 24'h000003);
    set_ovc(1'b0);
    n = 0;
    while (ao_hiz !== 1'b0 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("recovery bound", 24'h000001, 24'(n <= RETRY + 4));
    chk("ao_cfg restored", 24'h000001, 24'(ao_cfg));
    rd(ovd_pkg::REG_STAT, d);
    chk("status auto", 24'h000003, d & 24'h000003);
    // A one-cycle pulse trips once, so the output stays off exactly one interval
    set_ovc(1'b1);
    set_ovc(1'b0);
    n = 0;
    for (int k = 0; k < 2 * RETRY + 4; k++) begin
      cyc(1);
      if (ao_hiz === 1'b1) begin
        n++;
      end
    end
    chk("retry interval", 24'(RETRY), 24'(n));
    chk("ao_cfg after pulse", 24'h000001, 24'(ao_cfg));
    wr(ovd_pkg::REG_STAT, 24'h000007);
    cyc(2);
    chk("irq cleared", 24'h000000, 24'(irq));
    $display("test auto done");
  endtask

  task automatic t_host();
    logic [23:0] d;
    wr(ovd_pkg::REG_AO_CFG, 24'h020008);
    chk("ao_cfg v12p5", 24'h000002, 24'(ao_cfg));
    set_ovc(1'b1);
    cyc(5);
    chk("ao_hiz host trip", 24'h000001, 24'(ao_hiz));
    set_ovc(1'b0);
    cyc(4 * RETRY);
    chk("ao_hiz host hold", 24'h000001, 24'(ao_hiz));
    rd(ovd_pkg::REG_AO_CFG, d);
    chk("cfg field cleared", 24'h000000, 24'(d[19:16]));
    wr(ovd_pkg::REG_AO_CFG, 24'h020008);
    chk("ao_cfg rewritten", 24'h000002, 24'(ao_cfg));
    chk("ao_hiz rewritten", 24'h000000, 24'(ao_hiz));
    wr(ovd_pkg::REG_STAT, 24'h000007);
    $display("test host done");
  endtask

  // Current mode ignores overcurrent whatever the select bit says
  task automatic t_curr();
    logic [23:0] d;
    for (int s = 0; s < 2; s++) begin
      wr(ovd_pkg::REG_AO_CFG, 24'h060000 | 24'(s * 8));
      set_ovc(1'b1);
      cyc(RETRY + 5);
      chk("ao_cfg current", 24'h000006, 24'(ao_cfg));
      chk("ao_hiz current", 24'h000000, 24'(ao_hiz));
      set_ovc(1'b0);
      cyc(4);
    end
    wr(ovd_pkg::REG_AO_CFG, 24'h030000);
    chk("ao_cfg reserved", 24'h000006, 24'(ao_cfg));
    rd(ovd_pkg::REG_STAT, d);
    chk("status", 24'h000004, d & 24'h000007);
    $display("test current done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence: reset held for five clocks, then the scenarios
  initial begin
    errors   = 0;
    compares = 0;
    rst      = 1'b1;
    addr     = 8'h00;
    wdata    = 24'h000000;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    ovc_pin  = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_diag();
    t_auto();
    t_host();
    t_curr();
    conclude();
  end

  // Watchdog: the scenarios need well under a thousand cycles
  initial begin
    #50000;
    errors++;
    conclude();
  end
endmodule
